// ---- include/cfbs_pkg.sv ----
/*
 Package for the core flag and bank-select block: special register addresses,
 field positions, reset values, operation codes and carrier structs.
 Assumes an 8-bit special-register space driven by the core execution path.
*/
package cfbs_pkg;
  // Special register addresses in bank 0
  localparam logic [7:0] ADDR_IND0 = 8'h00;
  localparam logic [7:0] ADDR_PTR0 = 8'h01;
  localparam logic [7:0] ADDR_IND1 = 8'h02;
  localparam logic [7:0] ADDR_PTR1 = 8'h03;
  localparam logic [7:0] ADDR_BANK = 8'h04;
  localparam logic [7:0] ADDR_WREG = 8'h05;
  localparam logic [7:0] ADDR_PCLO = 8'h06;
  localparam logic [7:0] ADDR_TBLO = 8'h07;
  localparam logic [7:0] ADDR_TBDH = 8'h08;
  localparam logic [7:0] ADDR_TBHI = 8'h09;
  localparam logic [7:0] ADDR_FLAG = 8'h0a;
  // Flag register fields
  localparam int FLG_CARRY = 0;
  localparam int FLG_HALF = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_OVF = 3;
  localparam int FLG_PDF = 4;
  localparam int FLG_WDT = 5;
  localparam int BANK_W = 3;
  localparam logic [2:0] BANK_RST = 3'h0;
  localparam logic [2:0] BANK_CODE0 = 3'h0;
  localparam logic [2:0] BANK_CODE4 = 3'h4;
  localparam logic [3:0] FLAG_ARITH_RST = 4'h0;
  localparam int PC_W = 13;
  // Operations issued by the execution path
  typedef enum logic [3:0] {
    CFBS_OP_NONE = 4'h0,
    CFBS_OP_ADD  = 4'h1,
    CFBS_OP_SUB  = 4'h2,
    CFBS_OP_LOGIC = 4'h3,
    CFBS_OP_RLC  = 4'h4,
    CFBS_OP_RRC  = 4'h5
  } cfbs_op_t;
  typedef struct packed {
    cfbs_op_t op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic carry_in;
    logic to_wreg;
  } cfbs_alu_req_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfbs_reg_req_t;
  typedef struct packed {
    logic [7:0] data;
    logic [8:0] mem_addr;
    logic dir_bank0;
  } cfbs_mem_route_t;
endpackage : cfbs_pkg

// ---- hdl/cfbs_alu.sv ----
/*
 Combinational 8-bit ALU with flag generation for the core flag block.
 Assumes operands come from the working register and data memory on mclk.
*/
`timescale 1ns/1ns
module cfbs_alu import cfbs_pkg::*; (
  // Request
  input wire cfbs_alu_req_t req,
  // Result
  output logic [7:0] res,
  output logic [3:0] flags,
  output logic flags_vld
);
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum7;
  logic [7:0] opb_eff;
  logic cin;
  always_comb begin
    sum9 = 9'h000;
    sum5 = 5'h00;
    sum7 = 8'h00;
    res = 8'h00;
    flags = 4'h0;
    flags_vld = 1'b1;
    // Subtraction as add of inverse; carry out then means no borrow
    opb_eff = (req.op == CFBS_OP_SUB) ? ~req.opb : req.opb;
    cin = (req.op == CFBS_OP_SUB) ? 1'b1 : req.carry_in;
    unique case (req.op)
      CFBS_OP_ADD, CFBS_OP_SUB: begin
        sum9 = {1'b0, req.opa} + {1'b0, opb_eff} + {8'h00, cin};
        sum5 = {1'b0, req.opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin};
        sum7 = {1'b0, req.opa[6:0]} + {1'b0, opb_eff[6:0]} + {7'h00, cin};
        res = sum9[7:0];
        flags[FLG_CARRY] = sum9[8];
        flags[FLG_HALF] = sum5[4];
        flags[FLG_OVF] = sum7[7] ^ sum9[8];
        flags[FLG_ZERO] = (sum9[7:0] == 8'h00);
      end
      CFBS_OP_LOGIC: begin
        res = req.opa;
        flags[FLG_ZERO] = (req.opa == 8'h00);
      end
      CFBS_OP_RLC: begin
        res = {req.opa[6:0], req.carry_in};
        flags[FLG_CARRY] = req.opa[7];
      end
      CFBS_OP_RRC: begin
        res = {req.carry_in, req.opa[7:1]};
        flags[FLG_CARRY] = req.opa[0];
      end
      default: flags_vld = 1'b0;
    endcase
  end
endmodule : cfbs_alu

// ---- hdl/cfbs_core_regs.sv ----
/*
 Special registers of the core: flags, bank select, working register,
 program counter low byte, table latch and data memory routing.
 Assumes the execution path issues one request per cycle on mclk.
*/
`timescale 1ns/1ns
module cfbs_core_regs import cfbs_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic wdt_idle_rst,
  // Execution path requests
  input wire cfbs_reg_req_t reg_req,
  input wire logic reg_indirect,
  input wire cfbs_alu_req_t alu_req,
  input wire logic wdt_timeout,
  input wire logic wdt_clear_instr,
  input wire logic sleep_instr,
  input wire logic table_rd,
  input wire logic [15:0] prog_word,
  input wire logic [PC_W-1:0] pc_now,
  input wire logic [7:0] mem_rdata,
  // Answers
  output logic [7:0] reg_rdata,
  output logic [7:0] working_register,
  output logic [7:0] flags_out,
  output logic [2:0] bank_select_bits,
  output logic [8:0] mem_addr,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic pc_load,
  output logic [PC_W-1:0] pc_target,
  output logic dummy_cycle,
  output logic [15:0] table_addr,
  output logic [7:0] table_low_byte,
  output logic table_low_vld,
  output logic [7:0] table_data_high_latch
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] wreg;
    logic [3:0] arith;
    logic wdt_flag;
    logic pd_flag;
    logic [2:0] bank;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [7:0] tbl_lo;
    logic [7:0] tbl_hi;
    logic [7:0] tbl_dh;
    logic [8:0] maddr;
    logic mwr;
    logic [7:0] mwdata;
    logic pcld;
    logic [PC_W-1:0] pctgt;
    logic dummy;
    logic [7:0] tlow;
    logic tlow_vld;
    logic mrd;
  } cfbs_state_t;
  cfbs_state_t st_ff;
  cfbs_state_t nxt_st;
  logic [7:0] alu_res;
  logic [3:0] alu_flags;
  logic alu_vld;
  logic [7:0] flag_byte;
  logic bank_ok;
  logic [7:0] ind_ptr;
  logic add_carry_ref;

  cfbs_alu u_alu (
    .req(alu_req),
    .res(alu_res),
    .flags(alu_flags),
    .flags_vld(alu_vld)
  );

  assign flag_byte = {2'b00, st_ff.wdt_flag, st_ff.pd_flag, st_ff.arith};
  assign bank_ok = (st_ff.bank == BANK_CODE0) || (st_ff.bank == BANK_CODE4);
  assign ind_ptr = (reg_req.addr == ADDR_IND0) ? st_ff.ptr0 : st_ff.ptr1;
  // Carry reference kept apart from the ALU for its check
  assign add_carry_ref = ({1'b0, alu_req.opa} + {1'b0, alu_req.opb} + 9'(alu_req.carry_in)) > 9'h0ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.mwr = 1'b0;
    nxt_st.pcld = 1'b0;
    nxt_st.dummy = st_ff.pcld;
    nxt_st.tlow_vld = 1'b0;
    nxt_st.rdata = 8'h00;
    nxt_st.mrd = 1'b0;
    // Memory data arrive a cycle after the address goes out
    // Keep a gap after a memory read; a register read there wins
    if (st_ff.mrd) begin
      nxt_st.rdata = mem_rdata;
    end
    // Flags from the ALU first; a register write to flags overrides them
    if (alu_vld) begin
      if (alu_req.op inside {CFBS_OP_ADD, CFBS_OP_SUB}) begin
        nxt_st.arith = alu_flags;
      end else if (alu_req.op == CFBS_OP_LOGIC) begin
        nxt_st.arith[FLG_ZERO] = alu_flags[FLG_ZERO];
      end else begin
        nxt_st.arith[FLG_CARRY] = alu_flags[FLG_CARRY];
      end
      // Results land in the working register only
      if (alu_req.to_wreg) begin
        nxt_st.wreg = alu_res;
      end
    end
    // Sleep clears watchdog flag; a timeout in the same cycle wins
    if (wdt_clear_instr || sleep_instr) begin
      nxt_st.wdt_flag = 1'b0;
    end
    if (wdt_timeout) begin
      nxt_st.wdt_flag = 1'b1;
    end
    if (wdt_clear_instr) begin
      nxt_st.pd_flag = 1'b0;
    end else if (sleep_instr) begin
      nxt_st.pd_flag = 1'b1;
    end
    if (reg_req.rd) begin
      if (reg_indirect) begin
        // Reserved bank reads zero; otherwise fetch through the pointer
        if (reg_req.addr == ADDR_IND1 && !bank_ok) begin
          nxt_st.rdata = 8'h00;
        end else begin
          nxt_st.maddr = {(reg_req.addr == ADDR_IND1) && (st_ff.bank == BANK_CODE4), ind_ptr};
          nxt_st.mrd = 1'b1;
        end
      end else begin
        unique case (reg_req.addr)
          ADDR_PTR0: nxt_st.rdata = st_ff.ptr0;
          ADDR_PTR1: nxt_st.rdata = st_ff.ptr1;
          ADDR_BANK: nxt_st.rdata = {5'h00, st_ff.bank};
          ADDR_WREG: nxt_st.rdata = st_ff.wreg;
          ADDR_PCLO: nxt_st.rdata = pc_now[7:0];
          ADDR_TBLO: nxt_st.rdata = st_ff.tbl_lo;
          ADDR_TBDH: nxt_st.rdata = st_ff.tbl_dh;
          ADDR_TBHI: nxt_st.rdata = st_ff.tbl_hi;
          ADDR_FLAG: nxt_st.rdata = flag_byte;
          default: begin
            // Memory reads answer one cycle later than register reads
            nxt_st.maddr = {1'b0, reg_req.addr};
            nxt_st.mrd = 1'b1;
          end
        endcase
      end
    end
    if (reg_req.wr) begin
      if (reg_indirect) begin
        nxt_st.maddr = {(reg_req.addr == ADDR_IND1) && (st_ff.bank == BANK_CODE4), ind_ptr};
        nxt_st.mwdata = reg_req.wdata;
        nxt_st.mwr = (reg_req.addr != ADDR_IND1) || bank_ok;
      end else begin
        unique case (reg_req.addr)
          ADDR_PTR0: nxt_st.ptr0 = reg_req.wdata;
          ADDR_PTR1: nxt_st.ptr1 = reg_req.wdata;
          ADDR_BANK: nxt_st.bank = reg_req.wdata[BANK_W-1:0];
          ADDR_WREG: nxt_st.wreg = reg_req.wdata;
          ADDR_PCLO: begin
            nxt_st.pcld = 1'b1;
            nxt_st.pctgt = {pc_now[PC_W-1:8], reg_req.wdata};
          end
          ADDR_TBLO: nxt_st.tbl_lo = reg_req.wdata;
          ADDR_TBHI: nxt_st.tbl_hi = reg_req.wdata;
          ADDR_FLAG: nxt_st.arith = reg_req.wdata[3:0];
          ADDR_IND0, ADDR_IND1, ADDR_TBDH: nxt_st.mwr = 1'b0;
          default: begin
            // Direct addressing never sees the bank select
            nxt_st.maddr = {1'b0, reg_req.addr};
            nxt_st.mwdata = reg_req.wdata;
            nxt_st.mwr = 1'b1;
          end
        endcase
      end
    end
    if (table_rd) begin
      nxt_st.tbl_dh = prog_word[15:8];
      nxt_st.tlow = prog_word[7:0];
      nxt_st.tlow_vld = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.arith <= FLAG_ARITH_RST;
      // Watchdog reset while idle keeps the bank
      st_ff.bank <= wdt_idle_rst ? st_ff.bank : BANK_RST;
      // Flags are not touched by calls; no save path exists
      st_ff.wdt_flag <= wdt_idle_rst ? 1'b1 : 1'b0;
      st_ff.pd_flag <= wdt_idle_rst ? st_ff.pd_flag : 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign working_register = st_ff.wreg;
  assign flags_out = flag_byte;
  assign bank_select_bits = st_ff.bank;
  assign mem_addr = st_ff.maddr;
  assign mem_wr = st_ff.mwr;
  assign mem_wdata = st_ff.mwdata;
  assign pc_load = st_ff.pcld;
  assign pc_target = st_ff.pctgt;
  assign dummy_cycle = st_ff.dummy;
  assign table_addr = {st_ff.tbl_hi, st_ff.tbl_lo};
  assign table_low_byte = st_ff.tlow;
  assign table_low_vld = st_ff.tlow_vld;
  assign table_data_high_latch = st_ff.tbl_dh;

  chk_bank_upper_zero: assert property (@(posedge mclk) disable iff (rst)
    reg_req.rd && !reg_indirect && reg_req.addr == ADDR_BANK |=> reg_rdata[7:3] == 5'h00)
    else $error("bank select upper bits not zero");
  chk_flag_write_safe: assert property (@(posedge mclk) disable iff (rst)
    reg_req.wr && !reg_indirect && reg_req.addr == ADDR_FLAG && !wdt_timeout && !sleep_instr && !wdt_clear_instr
    |=> flags_out[5:4] == $past(flags_out[5:4]))
    else $error("flag write changed protected flags");
  chk_wdt_flag_set: assert property (@(posedge mclk) disable iff (rst)
    wdt_timeout |=> flags_out[FLG_WDT])
    else $error("watchdog flag not set");
  chk_pd_flag_sleep: assert property (@(posedge mclk) disable iff (rst)
    sleep_instr && !wdt_clear_instr |=> flags_out[FLG_PDF] && ($past(wdt_timeout) || !flags_out[FLG_WDT]))
    else $error("powerdown flag not set by sleep");
  chk_pcl_dummy: assert property (@(posedge mclk) disable iff (rst)
    reg_req.wr && !reg_indirect && reg_req.addr == ADDR_PCLO |=> pc_load ##1 dummy_cycle)
    else $error("low counter write without dummy cycle");
  chk_table_latch: assert property (@(posedge mclk) disable iff (rst)
    table_rd |=> table_data_high_latch == $past(prog_word[15:8]) && table_low_vld)
    else $error("table high latch wrong");
  chk_direct_bank0: assert property (@(posedge mclk) disable iff (rst)
    mem_wr && !$past(reg_indirect) |-> mem_addr[8] == 1'b0)
    else $error("direct access left bank 0");
  chk_add_carry: assert property (@(posedge mclk) disable iff (rst)
    alu_req.op == CFBS_OP_ADD && !(reg_req.wr && reg_req.addr == ADDR_FLAG)
    |=> flags_out[FLG_CARRY] == $past(add_carry_ref))
    else $error("carry flag wrong after add");
  chk_reserved_inert: assert property (@(posedge mclk) disable iff (rst)
    reg_req.wr && reg_indirect && reg_req.addr == ADDR_IND1 && !bank_ok |=> !mem_wr)
    else $error("write reached memory under reserved bank");
endmodule : cfbs_core_regs

// ---- verification/cfbs_mem_model.sv ----
/*
 Data memory model on the far side of the special register block.
 Assumes registered address and write strobe from the block on mclk.
*/
`timescale 1ns/1ns
module cfbs_mem_model (
  // Clock
  input wire logic mclk,
  // Memory port
  input wire logic [8:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  // Bit 8 keeps the two banks apart
  logic [7:0] mem_ff [512];
  initial begin
    // Fill of address xor 5a, so a stray read returns zero only at 0x05a and 0x15a
    for (int i = 0; i < 512; i++) begin
      mem_ff[i] = 8'(i) ^ 8'h5a;
    end
  end
  assign mem_rdata = mem_ff[mem_addr];
  always @(posedge mclk) begin
    if (mem_wr) begin
      mem_ff[mem_addr] <= mem_wdata;
    end
  end
endmodule : cfbs_mem_model

// ---- verification/tb_cfbs_core_regs.sv ----
/*
 Self-checking bench of the core special register block.
 Assumes the package constants and the data memory model beside it.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_cfbs_core_regs import cfbs_pkg::*; ;
  logic mclk, rst, wdt_idle_rst, reg_indirect, wdt_timeout, wdt_clear_instr, sleep_instr, table_rd;
  cfbs_reg_req_t reg_req;
  cfbs_alu_req_t alu_req;
  logic [15:0] prog_word, table_addr;
  logic [PC_W-1:0] pc_now, pc_target;
  logic [7:0] mem_rdata, reg_rdata, working_register, flags_out, mem_wdata, table_low_byte, table_data_high_latch;
  logic [2:0] bank_select_bits;
  logic [8:0] mem_addr;
  logic mem_wr, pc_load, dummy_cycle, table_low_vld;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  cfbs_core_regs u_dut (.mclk, .rst, .wdt_idle_rst, .reg_req, .reg_indirect, .alu_req, .wdt_timeout,
    .wdt_clear_instr, .sleep_instr, .table_rd, .prog_word, .pc_now, .mem_rdata, .reg_rdata,
    .working_register, .flags_out, .bank_select_bits, .mem_addr, .mem_wr, .mem_wdata, .pc_load,
    .pc_target, .dummy_cycle, .table_addr, .table_low_byte, .table_low_vld, .table_data_high_latch);
  cfbs_mem_model u_mem (.mclk, .mem_addr, .mem_wr, .mem_wdata, .mem_rdata);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // The whole run ends well before this; a hang is cut at cycle 3000
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict;
    end
  end

  task automatic tick;
    @(negedge mclk);
    reg_req = '0;
    reg_indirect = 1'b0;
    alu_req = '0;
    {wdt_timeout, wdt_clear_instr, sleep_instr, table_rd} = 4'h0;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ind);
    @(negedge mclk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    reg_indirect = ind;
    tick;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic ind, input logic [7:0] e);
    @(negedge mclk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    reg_indirect = ind;
    tick;
    `CHK(reg_rdata, e)
  endtask : rd

  // Data memory answers one cycle later than a register
  task automatic rdm(input logic [7:0] a, input logic ind, input logic [7:0] e);
    @(negedge mclk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    reg_indirect = ind;
    tick;
    @(negedge mclk);
    `CHK(reg_rdata, e)
  endtask : rdm

  task automatic pulse(input int k);
    @(negedge mclk);
    case (k)
      0: sleep_instr = 1'b1;
      1: wdt_timeout = 1'b1;
      3: {sleep_instr, wdt_timeout} = 2'b11;
      default: wdt_clear_instr = 1'b1;
    endcase
    tick;
  endtask : pulse

  task automatic alu(input cfbs_op_t op, input logic [7:0] a, input logic [7:0] b, input logic cin,
    input logic [7:0] er, input logic [3:0] ef, input logic [3:0] m);
    @(negedge mclk);
    alu_req = '{op: op, opa: a, opb: b, carry_in: cin, to_wreg: 1'b1};
    tick;
    `CHK(working_register, er)
    `CHK(flags_out[3:0] & m, ef)
  endtask : alu

  task automatic do_reset(input logic idle_wdt);
    @(negedge mclk);
    rst = 1'b1;
    wdt_idle_rst = idle_wdt;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    wdt_idle_rst = 1'b0;
  endtask : do_reset

  task automatic t_bank;
    rd(ADDR_FLAG, 1'b0, 8'h00);
    rd(ADDR_BANK, 1'b0, 8'h00);
    wr(ADDR_BANK, 8'hfc, 1'b0);
    `CHK(bank_select_bits, BANK_CODE4)
    rd(ADDR_BANK, 1'b0, 8'h04);
    wr(ADDR_PTR1, 8'h10, 1'b0);
    wr(ADDR_IND1, 8'ha5, 1'b1);
    `CHK({mem_wr, mem_addr, mem_wdata}, {1'b1, 9'h110, 8'ha5})
    wr(8'h10, 8'h3c, 1'b0);
    `CHK({mem_wr, mem_addr}, {1'b1, 9'h010})
    rdm(ADDR_IND1, 1'b1, 8'ha5);
    rdm(8'h10, 1'b0, 8'h3c);
    wr(ADDR_PTR0, 8'h10, 1'b0);
    rdm(ADDR_IND0, 1'b1, 8'h3c);
    wr(ADDR_BANK, 8'h01, 1'b0);
    `CHK(bank_select_bits, 3'h1)
    wr(ADDR_IND1, 8'h77, 1'b1);
    `CHK(mem_wr, 1'b0)
    rdm(ADDR_IND1, 1'b1, 8'h00);
    $display("bank test done");
  endtask : t_bank

  task automatic t_alu;
    alu(CFBS_OP_ADD, 8'h0f, 8'h01, 1'b0, 8'h10, 4'h2, 4'hf);
    alu(CFBS_OP_ADD, 8'h80, 8'h80, 1'b0, 8'h00, 4'hd, 4'hf);
    alu(CFBS_OP_ADD, 8'h7f, 8'h01, 1'b0, 8'h80, 4'ha, 4'hf);
    alu(CFBS_OP_SUB, 8'h05, 8'h03, 1'b0, 8'h02, 4'h3, 4'hf);
    alu(CFBS_OP_SUB, 8'h03, 8'h05, 1'b0, 8'hfe, 4'h0, 4'hf);
    alu(CFBS_OP_SUB, 8'h80, 8'h01, 1'b0, 8'h7f, 4'h9, 4'hf);
    alu(CFBS_OP_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00, 4'h4, 4'h4);
    alu(CFBS_OP_RLC, 8'h80, 8'h00, 1'b0, 8'h00, 4'h1, 4'h1);
    alu(CFBS_OP_RRC, 8'h01, 8'h00, 1'b1, 8'h80, 4'h1, 4'h1);
    rd(ADDR_WREG, 1'b0, 8'h80);
    $display("alu test done");
  endtask : t_alu

  task automatic t_flags;
    wr(ADDR_FLAG, 8'hff, 1'b0);
    `CHK(flags_out, 8'h0f)
    pulse(0);
    `CHK(flags_out[5:4], 2'b01)
    pulse(1);
    `CHK(flags_out[5:4], 2'b11)
    wr(ADDR_FLAG, 8'h00, 1'b0);
    `CHK(flags_out, 8'h30)
    pulse(0);
    `CHK(flags_out[5:4], 2'b01)
    pulse(1);
    pulse(2);
    `CHK(flags_out[5:4], 2'b00)
    pulse(3);
    `CHK(flags_out[5:4], 2'b11)
    $display("flag test done");
  endtask : t_flags

  task automatic t_pcl_table;
    wr(ADDR_PCLO, 8'h3c, 1'b0);
    `CHK({pc_load, pc_target}, {1'b1, 13'h1a3c})
    @(negedge mclk);
    `CHK({pc_load, dummy_cycle}, 2'b01)
    wr(ADDR_TBLO, 8'h34, 1'b0);
    wr(ADDR_TBHI, 8'h12, 1'b0);
    `CHK(table_addr, 16'h1234)
    @(negedge mclk);
    table_rd = 1'b1;
    tick;
    `CHK({table_data_high_latch, table_low_byte, table_low_vld}, {16'hbeef, 1'b1})
    rd(ADDR_TBDH, 1'b0, 8'hbe);
    $display("program counter and table test done");
  endtask : t_pcl_table

  task automatic t_wdt_reset;
    wr(ADDR_BANK, 8'h04, 1'b0);
    do_reset(1'b1);
    `CHK({bank_select_bits, flags_out[5:4]}, {BANK_CODE4, 2'b11})
    do_reset(1'b0);
    `CHK({bank_select_bits, flags_out}, {BANK_RST, 8'h00})
    $display("watchdog reset test done");
  endtask : t_wdt_reset

  initial begin
    reg_req = '0;
    reg_indirect = 1'b0;
    alu_req = '0;
    {wdt_timeout, wdt_clear_instr, sleep_instr, table_rd} = 4'h0;
    rst = 1'b1;
    wdt_idle_rst = 1'b0;
    pc_now = 13'h1a55;
    prog_word = 16'hbeef;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    t_bank;
    t_alu;
    t_flags;
    t_pcl_table;
    t_wdt_reset;
    give_verdict;
  end
endmodule : tb_cfbs_core_regs
